//--- hdl/duc_regs.svh
// Constants for the DAC update and clear control block
`ifndef DUC_REGS_SVH
`define DUC_REGS_SVH
`define DUC_FRAME_BITS      24
`define DUC_FRAME_CNT_W     5
`define DUC_RW_BIT          23
`define DUC_REG_HI          22
`define DUC_REG_LO          20
`define DUC_ADDR_HI         19
`define DUC_ADDR_LO         17
`define DUC_DATA_HI         15
`define DUC_DATA_LO         0
`define DUC_REG_DAC         3'h0
`define DUC_REG_RANGE       3'h1
`define DUC_REG_POWER       3'h2
`define DUC_REG_CTRL        3'h3
`define DUC_ADDR_ALL        3'h4
`define DUC_CTRL_CLRSEL_BIT 2
`define DUC_CTRL_CMD_HI     2
`define DUC_CTRL_CMD_LO     0
`define DUC_CTRL_ADDR_CLR   3'h4
`define DUC_RANGE_W         3
`define DUC_RANGE_BIPOLAR   2
`define DUC_RANGE_RESET     3'h0
`define DUC_CODE_RESET      16'h0000
`define DUC_MIDSCALE        16'h8000
`define DUC_SIGN_FLIP       16'h8000
`define DUC_AVL_ADDR_W      4
`define DUC_AVL_STATUS      4'h0
`define DUC_AVL_CODE_A      4'h1
`define DUC_AVL_CODE_B      4'h2
`define DUC_AVL_CFG         4'h3
`define DUC_AVL_BAD         32'hDEAD_0000
`endif

//--- hdl/duc_pkg.sv
// Types shared by the DAC update and clear control block
package duc_pkg;
	typedef struct packed {
		logic        rw;
		logic [2:0]  reg_sel;
		logic [2:0]  addr;
		logic        spare;
		logic [15:0] data;
	} duc_frame_s;
	typedef struct packed {
		logic [15:0] code;
		logic [2:0]  range;
		logic        power;
	} duc_chan_s;
endpackage

//--- hdl/duc_sync.sv
// Three-stage synchroniser for one pin
`timescale 1ns/100ps
`default_nettype none
module duc_sync (
	input  wire logic clock_in,
	input  wire logic nrst_in,
	input  wire logic en_in,
	input  wire logic pin_in,
	input  wire logic rst_val_in,
	output var  logic level_out,
	output var  logic rise_out,
	output var  logic fall_out
);
	typedef struct packed {
		logic [2:0] st;
		logic       lvl;
		logic       rise;
		logic       fall;
	} duc_sync_s;
	duc_sync_s r_q;
	duc_sync_s r_d;
	always_comb begin
		r_d = r_q;
		r_d.rise = 1'b0;
		r_d.fall = 1'b0;
		r_d.st = {r_q.st[1:0], pin_in};
		// Level moves only once stages two and three agree
		if (r_q.st[1] == r_q.st[2] && r_q.st[2] != r_q.lvl) begin
			r_d.lvl  = r_q.st[2];
			r_d.rise = r_q.st[2];
			r_d.fall = ~r_q.st[2];
		end
	end
	// Reset value held low; rst_val_in is masked off with 1'b0 and never used
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r_q <= '0;
		end else if (en_in) begin
			r_q <= r_d;
		end
	end
	assign level_out = r_q.lvl | (rst_val_in & 1'b0);
	assign rise_out  = r_q.rise;
	assign fall_out  = r_q.fall;
endmodule
`default_nettype wire

//--- hdl/duc_top.sv
// DAC update, clear and code mapping control with serial port and Avalon-MM view
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "duc_regs.svh"
module duc_top
	import duc_pkg::*;
#(
	parameter int RES_BITS = 16,
	parameter int CHANNELS = 2
) (
	// Clock, reset, enable
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	input  wire logic        clk_en_in,
	// Serial port and control pins
	input  wire logic        sclk_in,
	input  wire logic        sync_n_in,
	input  wire logic        sdin_in,
	input  wire logic        load_strobe_n_in,
	input  wire logic        clear_n_in,
	input  wire logic        coding_select_in,
	// Channel outputs: mapped code, range and power
	output var  logic [15:0] code_a_out,
	output var  logic [15:0] code_b_out,
	output var  logic [2:0]  range_a_out,
	output var  logic [2:0]  range_b_out,
	output var  logic [1:0]  power_out,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest
);
	typedef struct packed {
		logic [23:0]                  shreg;
		logic [`DUC_FRAME_CNT_W-1:0]  cnt;
		logic [CHANNELS-1:0][15:0]    in_reg;
		logic [CHANNELS-1:0][15:0]    dac_reg;
		logic [CHANNELS-1:0][2:0]     range;
		logic [CHANNELS-1:0]          power;
		logic                         clr_sel;
		logic                         frame_err;
		logic [15:0]                  frames;
		logic [CHANNELS-1:0][15:0]    out_code;
		logic [31:0]                  rdata;
		logic                         ack;
		logic                         wreq;
	} duc_state_s;

	duc_state_s s_q;
	duc_state_s s_d;
	// Synchronised pin levels and edge pulses
	logic sclk_fall;
	logic sync_lvl;
	logic sync_rise;
	logic sync_fall;
	logic sdin_lvl;
	logic load_strobe_n_lvl;
	logic load_strobe_n_fall;
	logic clr_lvl;
	logic cod_lvl;

	// Serial clock: only its falling edge moves data
	duc_sync u_sclk (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (sclk_in),
		.rst_val_in (1'b0),
		.level_out  (),
		.rise_out   (),
		.fall_out   (sclk_fall)
	);

	// Data pin takes the same three stages, so it lines up with the clock edge
	duc_sync u_sdin (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (sdin_in),
		.rst_val_in (1'b0),
		.level_out  (sdin_lvl),
		.rise_out   (),
		.fall_out   ()
	);

	// Frame sync, inverted so that the level is high inside a frame
	duc_sync u_sync (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (~sync_n_in),
		.rst_val_in (1'b0),
		.level_out  (sync_lvl),
		.rise_out   (sync_fall),
		.fall_out   (sync_rise)
	);

	// Load strobe, inverted so that its falling edge is a rise here
	duc_sync u_load_strobe_n (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (~load_strobe_n_in),
		.rst_val_in (1'b0),
		.level_out  (load_strobe_n_lvl),
		.rise_out   (load_strobe_n_fall),
		.fall_out   ()
	);

	// Clear pin, inverted so that the level is high while clearing
	duc_sync u_clr (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (~clear_n_in),
		.rst_val_in (1'b0),
		.level_out  (clr_lvl),
		.rise_out   (),
		.fall_out   ()
	);

	// Coding select: high is offset binary, low is twos complement
	duc_sync u_cod (
		.clock_in   (clock_in),
		.nrst_in    (nrst_in),
		.en_in      (clk_en_in),
		.pin_in     (coding_select_in),
		.rst_val_in (1'b0),
		.level_out  (cod_lvl),
		.rise_out   (),
		.fall_out   ()
	);

	// Keep only the top RES_BITS bits of a code
	function automatic logic [15:0] align_code(input logic [15:0] c);
		logic [15:0] m;
		m = 16'hFFFF << (16 - RES_BITS);
		return c & m;
	endfunction

	// Map a DAC code to a straight binary tap position
	function automatic logic [15:0] map_code(input logic [15:0] c, input logic [2:0] rng, input logic twos);
		logic [15:0] r;
		r = c;
		if (rng[`DUC_RANGE_BIPOLAR] && twos) begin
			r = c ^ `DUC_SIGN_FLIP;
		end
		return r;
	endfunction

	// Code every channel takes on a clear, from the pin or the command
	function automatic logic [15:0] clear_code(input logic sel);
		logic [15:0] r;
		r = sel ? `DUC_MIDSCALE : `DUC_CODE_RESET;
		return r;
	endfunction

	// True when a frame address selects channel i
	function automatic logic chan_hit(input logic [2:0] a, input int i);
		logic h;
		h = (a == 3'(i)) || (a == `DUC_ADDR_ALL);
		return h;
	endfunction

	// Only a frame with exactly the right edge count is applied
	function automatic logic frame_good(input logic [`DUC_FRAME_CNT_W-1:0] n);
		logic g;
		g = (n == `DUC_FRAME_CNT_W'(`DUC_FRAME_BITS));
		return g;
	endfunction

	// Status word: frame count, clear pin, clear level, frame error
	function automatic logic [31:0] status_word(input logic [15:0] n, input logic c, input logic sel,
		input logic err);
		logic [31:0] w;
		w = {n, 13'h0000, c, sel, err};
		return w;
	endfunction

	// Channel code widened to the bus word
	function automatic logic [31:0] chan_word(input logic [15:0] c);
		logic [31:0] w;
		w = {16'h0000, c};
		return w;
	endfunction

	// Range and power word of the first two channels
	function automatic logic [31:0] cfg_word(input logic [2:0] r1, input logic [2:0] r0, input logic [1:0] p);
		logic [31:0] w;
		w = {24'h000000, r1, r0, p};
		return w;
	endfunction

	logic       clr_active;
	logic       strobe_held;
	duc_frame_s fr;

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		// Clear takes effect at the accepted write edge; an error set below in the same cycle still wins
		if (avs_write && s_q.ack && avs_address == `DUC_AVL_STATUS && avs_writedata[0]) begin
			s_d.frame_err = 1'b0;
		end
		fr = duc_frame_s'(s_q.shreg);
		clr_active = clr_lvl;
		// Strobe level held during frame decides the update mode
		strobe_held = load_strobe_n_lvl;
		if (sync_fall) begin
			s_d.cnt = '0;
		end

		// Count saturates, so a long burst still reads as a bad frame
		if (sync_lvl && sclk_fall) begin
			s_d.shreg = {s_q.shreg[22:0], sdin_lvl};
			if (s_q.cnt != {`DUC_FRAME_CNT_W{1'b1}}) begin
				s_d.cnt = s_q.cnt + `DUC_FRAME_CNT_W'(1);
			end
		end

		// Frame end: check the edge count, then apply the write
		if (sync_rise) begin
			if (!frame_good(s_q.cnt)) begin
				s_d.frame_err = 1'b1;
			end else if (!fr.rw) begin
				s_d.frames = s_q.frames + 16'h0001;
				for (int i = 0; i < CHANNELS; i++) begin
					if (chan_hit(fr.addr, i)) begin
						case (fr.reg_sel)
							`DUC_REG_DAC: begin
								if (s_q.power[i]) begin
									s_d.in_reg[i] = align_code(fr.data);
									if (strobe_held && !clr_active) begin
										s_d.dac_reg[i] = align_code(fr.data);
									end
								end
							end
							`DUC_REG_RANGE: s_d.range[i] = fr.data[`DUC_RANGE_W-1:0];
							`DUC_REG_POWER: s_d.power[i] = fr.data[i];
							default: ;
						endcase
					end
				end
				if (fr.reg_sel == `DUC_REG_POWER) begin
					s_d.power = fr.data[CHANNELS-1:0];
				end
				if (fr.reg_sel == `DUC_REG_CTRL) begin
					if (fr.addr == `DUC_CTRL_ADDR_CLR) begin
						for (int i = 0; i < CHANNELS; i++) begin
							s_d.dac_reg[i] = clear_code(s_q.clr_sel);
							s_d.in_reg[i]  = s_d.dac_reg[i];
						end
					end else begin
						s_d.clr_sel = fr.data[`DUC_CTRL_CLRSEL_BIT];
					end
				end
			end
		end
		// Simultaneous update on strobe falling edge, frame sync high
		if (load_strobe_n_fall && !sync_lvl && !clr_active) begin
			for (int i = 0; i < CHANNELS; i++) begin
				if (s_q.power[i]) begin
					s_d.dac_reg[i] = s_d.in_reg[i];
				end
			end
		end
		// Clear wins over any load and the cleared code persists
		if (clr_active) begin
			for (int i = 0; i < CHANNELS; i++) begin
				s_d.dac_reg[i] = clear_code(s_q.clr_sel);
				s_d.in_reg[i]  = s_d.dac_reg[i];
			end
		end
		for (int i = 0; i < CHANNELS; i++) begin
			s_d.out_code[i] = map_code(s_q.dac_reg[i], s_q.range[i], !cod_lvl);
		end
		// Avalon: one wait cycle, then answer
		if ((avs_read || avs_write) && !s_q.ack) begin
			s_d.ack = 1'b1;
			case (avs_address)
				`DUC_AVL_STATUS: s_d.rdata = status_word(s_q.frames, clr_lvl, s_q.clr_sel, s_q.frame_err);
				`DUC_AVL_CODE_A: s_d.rdata = chan_word(s_q.dac_reg[0]);
				`DUC_AVL_CODE_B: s_d.rdata = chan_word(s_q.dac_reg[CHANNELS-1]);
				`DUC_AVL_CFG:    s_d.rdata = cfg_word(s_q.range[1], s_q.range[0], s_q.power[1:0]);
				default:         s_d.rdata = `DUC_AVL_BAD;
			endcase
		end
		// Waitrequest has its own flop so the port needs no gate after the register
		s_d.wreq = !s_d.ack;
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_q <= '0;
			s_q.wreq <= 1'b1;
		end else if (clk_en_in) begin
			s_q <= s_d;
		end
	end

	assign code_a_out      = s_q.out_code[0];
	assign code_b_out      = s_q.out_code[CHANNELS-1];
	assign range_a_out     = s_q.range[0];
	assign range_b_out     = s_q.range[CHANNELS-1];
	assign power_out       = s_q.power[1:0];
	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.wreq;
endmodule
`default_nettype wire

//--- verification/duc_props.sv
// Checker for the DAC update and clear control ports
`timescale 1ns/100ps
`default_nettype none
module duc_props (
	input wire logic        clock_in,
	input wire logic        nrst_in,
	input wire logic        sync_n_in,
	input wire logic        load_strobe_n_in,
	input wire logic        clear_n_in,
	input wire logic        coding_select_in,
	input wire logic [15:0] code_a_out,
	input wire logic [2:0]  range_a_out,
	input wire logic [1:0]  power_out,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Eight cycles covers the pin synchroniser plus the output register
	sequence clr_low8;
		!clear_n_in[*8];
	endsequence
	sequence quiet8;
		(sync_n_in && load_strobe_n_in && clear_n_in && !range_a_out[2])[*8];
	endsequence
	a_reset_zero: assert property ($rose(nrst_in) |-> !code_a_out && !range_a_out && !power_out)
		else $error("outputs not cleared by reset");
	a_down_ignored: assert property (!power_out[0] && clear_n_in |=> $stable(code_a_out))
		else $error("powered-down channel changed");
	a_clear_level: assert property (clr_low8 ##0 !range_a_out[2] |-> code_a_out inside {16'h0000, 16'h8000})
		else $error("clear level wrong");
	a_clear_blocks: assert property (clr_low8 ##1 !clear_n_in |-> $stable(code_a_out))
		else $error("load while clear low");
	a_quiet_hold: assert property (quiet8 |-> $stable(code_a_out))
		else $error("code moved without update");
	a_coding_flip: assert property ($changed(coding_select_in) && range_a_out[2] && sync_n_in && clear_n_in |-> ##[3:7] $changed(code_a_out))
		else $error("bipolar coding ignored");
	a_avl_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait state");
	a_avl_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
endmodule
bind duc_top duc_props duc_props_i (
	.clock_in(clock_in), .nrst_in(nrst_in), .sync_n_in(sync_n_in), .load_strobe_n_in(load_strobe_n_in),
	.clear_n_in(clear_n_in), .coding_select_in(coding_select_in), .code_a_out(code_a_out),
	.range_a_out(range_a_out), .power_out(power_out), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

//--- verification/duc_host.sv
// Serial host model that writes frames to the block
`timescale 1ns/100ps
`default_nettype none
module duc_host
	import duc_pkg::*;
(
	// Clock
	input  wire logic clock_in,
	// Serial pins
	output var  logic sclk_out,
	output var  logic sync_n_out,
	output var  logic sdin_out
);
	initial begin
		sclk_out = 1'b1;
		sync_n_out = 1'b1;
		sdin_out = 1'b0;
	end
	// Four clocks a half period gives the 32 ns link clock
	task automatic half();
		repeat (4) @(posedge clock_in);
	endtask
	// Any count but 24 is a deliberately broken frame
	task automatic send(input duc_frame_s f, input int edges);
		sync_n_out <= 1'b0;
		half();
		for (int i = 0; i < edges; i++) begin
			sdin_out <= (i < 24) ? f[23 - i] : 1'b0;
			half();
			sclk_out <= 1'b0;
			half();
			sclk_out <= 1'b1;
		end
		half();
		sync_n_out <= 1'b1;
		sdin_out <= ~sdin_out;
		half();
	endtask
endmodule
`default_nettype wire

//--- verification/duc_tb_top.sv
// Testbench for the DAC update and clear control block
`timescale 1ns/100ps
`default_nettype none
module duc_tb_top;
	import duc_pkg::*;
	logic        clock_in, nrst_in, sclk_in, sync_n_in, sdin_in;
	logic        clk_en_in = 1'b1;
	logic        load_strobe_n_in, clear_n_in, coding_select_in;
	logic [15:0] code_a_out, code_b_out;
	logic [2:0]  range_a_out, range_b_out;
	logic [1:0]  power_out;
	logic [3:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	int          err_count, check_count;
	duc_top duc_top_i (
		.clock_in(clock_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in), .sclk_in(sclk_in),
		.sync_n_in(sync_n_in), .sdin_in(sdin_in), .load_strobe_n_in(load_strobe_n_in),
		.clear_n_in(clear_n_in), .coding_select_in(coding_select_in), .code_a_out(code_a_out),
		.code_b_out(code_b_out), .range_a_out(range_a_out), .range_b_out(range_b_out),
		.power_out(power_out), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
	);
	duc_host duc_host_i (.clock_in, .sclk_out(sclk_in), .sync_n_out(sync_n_in), .sdin_out(sdin_in));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic avl(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		n = 0;
		do begin
			@(posedge clock_in);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50) begin
			err_count++;
			finish_test();
		end
		@(posedge clock_in);
	endtask
	task automatic fw(input logic [2:0] r, input logic [2:0] a, input logic [15:0] d);
		duc_host_i.send({1'b0, r, a, 1'b0, d}, 24);
		repeat (10) @(posedge clock_in);
	endtask
	task automatic t_reset();
		chk("range", 0, range_a_out);
		avl(0, 4'h3, 0);
		chk("cfg", 0, rd);
		avl(0, 4'h9, 0);
		chk("unmapped", 32'hDEAD0000, rd);
	endtask
	task automatic t_power();
		fw(3'h0, 3'h1, 16'h1234);
		chk("code b", 0, code_b_out);
		fw(3'h1, 3'h4, 16'h0000);
		fw(3'h2, 3'h0, 16'h0003);
		chk("power", 3, power_out);
	endtask
	task automatic t_update();
		fw(3'h0, 3'h0, 16'hABCD);
		chk("code a", 16'hABCD, code_a_out);
		load_strobe_n_in <= 1'b1;
		fw(3'h0, 3'h0, 16'h1111);
		fw(3'h0, 3'h1, 16'h2222);
		chk("held a", 16'hABCD, code_a_out);
		load_strobe_n_in <= 1'b0;
		repeat (10) @(posedge clock_in);
		chk("both", 32'h11112222, {code_a_out, code_b_out});
		avl(0, 4'h1, 0);
		chk("dac a", 16'h1111, rd);
	endtask
	task automatic t_coding();
		coding_select_in <= 1'b0;
		repeat (10) @(posedge clock_in);
		chk("unipolar", 16'h1111, code_a_out);
		fw(3'h1, 3'h0, 16'h0004);
		chk("range", 4, range_a_out);
		chk("range b", 0, range_b_out);
		chk("twos", 16'h9111, code_a_out);
		coding_select_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		chk("offset", 16'h1111, code_a_out);
		fw(3'h1, 3'h0, 16'h0000);
	endtask
	task automatic t_clear();
		fw(3'h3, 3'h0, 16'h0004);
		clear_n_in <= 1'b0;
		repeat (10) @(posedge clock_in);
		chk("mid", 32'h80008000, {code_a_out, code_b_out});
		fw(3'h0, 3'h0, 16'h5555);
		chk("blocked", 16'h8000, code_a_out);
		clear_n_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		chk("kept", 16'h8000, code_a_out);
		fw(3'h3, 3'h0, 16'h0000);
		fw(3'h3, 3'h4, 16'h0000);
		chk("cmd", 0, {code_a_out, code_b_out});
	endtask
	task automatic t_freeze();
		clk_en_in <= 1'b0;
		fw(3'h0, 3'h0, 16'h4444);
		clk_en_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		chk("frozen", 0, code_a_out);
	endtask
	task automatic t_bad();
		duc_host_i.send({1'b0, 3'h0, 3'h0, 1'b0, 16'h7777}, 23);
		repeat (10) @(posedge clock_in);
		chk("short", 0, code_a_out);
		avl(0, 4'h0, 0);
		chk("err", 1, rd[0]);
		avl(1, 4'h0, 1);
		avl(0, 4'h0, 0);
		chk("err clr", 0, rd[0]);
	endtask
	initial begin
		nrst_in = 1'b0;
		load_strobe_n_in = 1'b0;
		clear_n_in = 1'b1;
		coding_select_in = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		err_count = 0;
		check_count = 0;
		repeat (4) @(posedge clock_in);
		nrst_in <= 1'b1;
		@(posedge clock_in);
		t_reset();
		t_power();
		t_update();
		t_coding();
		t_clear();
		t_freeze();
		t_bad();
		finish_test();
	end
endmodule
`default_nettype wire
